// ---- mso_pkg.sv ----
// Constants, enumerations and carriers for the meter serial override block.
// Assumes one 250 MHz clock; all users import the whole package.
package mso_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 250000;
  localparam int T2_MIN_MS = 2;
  localparam int T2_MAX_MS = 15;
  // Whole milliseconds at this rate give exact cycle counts.
  localparam int T2_MIN_CYC = T2_MIN_MS * CLK_KHZ;
  localparam int T2_MAX_CYC = T2_MAX_MS * CLK_KHZ;
  // ****************************************
  // Limits, reset values and counts
  // ****************************************
  localparam logic [11:0] LEVEL_MAX = 12'hfff;
  localparam int SCALE_MIN = -199999;
  localparam int SCALE_MAX = 999999;
  localparam logic [19:0] NUM_CAP = 20'h186a0;
  localparam logic [11:0] LVL_RESET = 12'h000;
  localparam logic [3:0] SP_RESET = 4'h0;
  localparam logic [4:0] AM_RESET = 5'h00;
  localparam logic [2:0] RSEL_RESET = 3'h1;
  localparam int N_SP = 4;
  localparam int N_FLD = 5;
  localparam int AM_ANALOG = 4;
  localparam logic [3:0] REPLY_LEN = 4'he;
  localparam logic [3:0] FIELD_POS = 4'h8;
  localparam logic [3:0] FRAME_LEN = 4'ha;
  localparam logic [3:0] FRAME_LEN_PAR = 4'hb;
  localparam logic [5:0] DIV_ITER = 6'h21;
  // ****************************************
  // Characters
  // ****************************************
  localparam logic [6:0] CH_T = 7'h54;
  localparam logic [6:0] CH_V = 7'h56;
  localparam logic [6:0] CH_U = 7'h55;
  localparam logic [6:0] CH_W = 7'h57;
  localparam logic [6:0] CH_X = 7'h58;
  localparam logic [6:0] CH_STAR = 7'h2a;
  localparam logic [6:0] CH_DOLLAR = 7'h24;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_0 = 7'h30;
  localparam logic [6:0] CH_1 = 7'h31;
  localparam logic [6:0] CH_9 = 7'h39;
  localparam logic [6:0] CH_SP = 7'h20;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_LF = 7'h0a;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    MSO_SRC_MANUAL = 4'h0, MSO_SRC_REL = 4'h1, MSO_SRC_ABS = 4'h2,
    MSO_SRC_TOTAL = 4'h3, MSO_SRC_MAX = 4'h4, MSO_SRC_MIN = 4'h5,
    MSO_SRC_SETPOINT_ONE = 4'h6, MSO_SRC_SETPOINT_TWO = 4'h7,
    MSO_SRC_SETPOINT_THREE = 4'h8, MSO_SRC_SETPOINT_FOUR = 4'h9
  } mso_src_t;
  typedef enum logic [1:0] {
    MSO_PAR_NONE = 2'h0, MSO_PAR_ODD = 2'h1, MSO_PAR_EVEN = 2'h2
  } mso_par_t;
  typedef enum logic [1:0] {
    MSO_OUT_0_20MA = 2'h0, MSO_OUT_4_20MA = 2'h1, MSO_OUT_0_10V = 2'h2
  } mso_out_t;
  typedef enum logic [2:0] {
    MSO_ST_RECV = 3'b001, MSO_ST_WAIT = 3'b010, MSO_ST_SEND = 3'b100
  } mso_st_t;
  // Programmed settings, held steady by the meter.
  typedef struct packed {
    logic [15:0] baud_div;
    logic seven_bits;
    mso_par_t parity;
    logic [31:0] tx_delay;
    mso_out_t out_type;
    mso_src_t src;
    logic signed [31:0] low_scale;
    logic signed [31:0] high_scale;
  } mso_cfg_t;
  // Live meter values that the analog output may retransmit, plus the automatic setpoint states.
  typedef struct packed {
    logic signed [31:0] abs_val;
    logic signed [31:0] offset;
    logic signed [31:0] total;
    logic signed [31:0] max_val;
    logic signed [31:0] min_val;
    logic [3:0][31:0] sp_val;
    logic [3:0] sp_auto;
  } mso_meter_t;
endpackage : mso_pkg

// ---- mso_scaler.sv ----
// Converts a display value to a 12-bit analog level code.
// Assumes steady scale inputs; a new result appears every 34 cycles or sooner.
`timescale 1ns/1ps
module mso_scaler
  import mso_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic signed [31:0] value,
  input wire logic signed [31:0] low,
  input wire logic signed [31:0] high,
  output logic [11:0] level
);
  typedef struct packed {
    logic [5:0] cnt;
    logic [32:0] dvd;
    logic [20:0] rem;
    logic [20:0] den;
    logic [11:0] level;
  } mso_scl_st_t;
  mso_scl_st_t q, n;
  logic signed [33:0] lo_c, hi_c, num, den;
  logic [21:0] trial;

  // Scale ends are held to the range a display value can take.
  function automatic logic signed [33:0] clamp_scale(input logic signed [31:0] v);
    if (v < SCALE_MIN) return 34'(SCALE_MIN);
    if (v > SCALE_MAX) return 34'(SCALE_MAX);
    return 34'(v);
  endfunction : clamp_scale

  // A serial divider keeps area small; the analog output tolerates the latency.
  always_comb
  begin
    n = q;
    trial = '0;
    lo_c = clamp_scale(low);
    hi_c = clamp_scale(high);
    if (hi_c < lo_c)
    begin
      num = lo_c - 34'(value);
      den = lo_c - hi_c;
    end
    else
    begin
      num = 34'(value) - lo_c;
      den = hi_c - lo_c;
    end
    if (q.cnt == 6'h00)
    begin
      if (num <= 0)
        n.level = '0;
      else if (num >= den)
        n.level = LEVEL_MAX;
      else
      begin
        n.dvd = 33'(num[20:0]) * 33'(LEVEL_MAX);
        n.den = den[20:0];
        n.rem = '0;
        n.cnt = DIV_ITER;
      end
    end
    else
    begin
      trial = {q.rem, q.dvd[32]};
      n.dvd = {q.dvd[31:0], 1'b0};
      if (trial >= {1'b0, q.den})
      begin
        n.rem = 21'(trial - {1'b0, q.den});
        n.dvd[0] = 1'b1;
      end
      else
        n.rem = trial[20:0];
      n.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01)
        n.level = n.dvd[11:0];
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= n;
  end

  assign level = q.level;

  AST_CLAMP_LOW: assert property (@(posedge clk) disable iff (!resetn)
    q.cnt == 6'h00 && num <= 0 |=> level == 12'h000)
    else $error("level not clamped to zero");
endmodule : mso_scaler

// ---- mso_serial_override.sv ----
// Serial side of a panel meter: receives commands, drives analog and setpoint outputs, replies.
// Assumes a 250 MHz clock, an async serial receive pin and steady configuration inputs.
// Notes on behaviour
// - Analog level register holds 0 to 4095 across the selected range.
// - Manual mode: analog level write drives the output immediately.
// - Automatic mode: analog level write is stored but not driven.
// - Analog level read returns the level now being driven.
// - Setpoint read returns four 0/1 characters, setpoint one first.
// - Setpoint write changes an output only for 0/1 fields in manual mode.
// - Missing trailing setpoint fields leave those outputs unchanged.
// - Half duplex: never receive and transmit together.
// - Command executes 2 to 15 ms after its terminator.
// - Asterisk reply starts within transmit delay plus 15 ms.
// - Dollar reply starts between 2 ms and 15 ms after terminator.
// - Each character takes ten bit periods, eleven with eight data bits and parity.
// - After the last reply character the next command is accepted at once.
// - Frame: start bit, then data bits least significant first.
// - Line idles at one, start bit is zero, any idle gap allowed.
// - Received parity ignored; sent parity odd, even or none.
// - Seven data bits without parity send two stop bits.
// - Source selection picks what the analog output retransmits.
// - Relative value is absolute value plus display offset.
// - Low-scale value, -199999 to 999999, maps to range bottom.
// - Exactly one analog range is selected at a time.
// - Each output has an auto/manual bit, one meaning manual.
// - High-scale value maps to range top.
// - No processing before the terminator arrives.
`timescale 1ns/1ps
module mso_serial_override
  import mso_pkg::*;
#(
  parameter int T2_CYC = T2_MIN_CYC
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_pin,
  input wire mso_cfg_t cfg,
  input wire mso_meter_t meter,
  output logic tx_pin,
  output logic tx_oe,
  output logic [11:0] analog_level,
  output logic [3:0] setpoint_out,
  output logic [2:0] range_sel
);
  if (T2_CYC < 1 || T2_CYC > T2_MAX_CYC)
    $error("T2_CYC out of range");

  localparam logic [31:0] T2_LAST = 32'(T2_CYC - 1);

  typedef struct packed {
    logic [1:0] sync;
    mso_st_t st;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [6:0] cmd;
    logic [6:0] rid;
    logic [19:0] num;
    logic neg;
    logic [9:0] fld;
    logic [2:0] nfld;
    logic star;
    logic [31:0] wcnt;
    logic [3:0] ridx;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic [11:0] lvl;
    logic [3:0] sp;
    logic [4:0] am;
    logic [11:0] aout;
    logic [3:0] spout;
    logic [2:0] rsel;
    logic tx;
    logic oe;
  } mso_main_st_t;
  mso_main_st_t q, n;

  logic got, rpl, an_man;
  logic [6:0] ch;
  logic [3:0] db, last, flen;
  logic [11:0] fr, scaled;
  logic signed [31:0] src_val;

  // ****************************************
  // Helpers
  // ****************************************
  // One reply character: right-justified twelve-wide field, then CR LF.
  function automatic logic [6:0] reply_char(input logic [3:0] i, input logic is_x,
                                            input logic [11:0] lv, input logic [3:0] sp);
    logic [11:0] d;
    d = '0;
    if (i >= REPLY_LEN - 4'h1)
      return CH_LF;
    if (i == REPLY_LEN - 4'h2)
      return CH_CR;
    if (i < FIELD_POS)
      return CH_SP;
    if (is_x)
      return sp[2'(i - FIELD_POS)] ? CH_1 : CH_0;
    unique case (2'(i - FIELD_POS))
      2'h0: d = lv / 12'd1000;
      2'h1: d = (lv / 12'd100) % 12'd10;
      2'h2: d = (lv / 12'd10) % 12'd10;
      default: d = lv % 12'd10;
    endcase
    if ((i == FIELD_POS && lv < 12'd1000) || (i == FIELD_POS + 4'h1 && lv < 12'd100) ||
        (i == FIELD_POS + 4'h2 && lv < 12'd10))
      return CH_SP;
    return CH_0 + d[6:0];
  endfunction : reply_char

  // Frame bits, first bit in position zero; unused positions stay at mark.
  function automatic logic [11:0] build_frame(input logic [6:0] c, input mso_cfg_t cf);
    logic [11:0] f;
    logic p;
    p = ^c;
    f = 12'hfff;
    f[0] = 1'b0;
    if (cf.seven_bits)
      f[7:1] = c;
    else
      f[8:1] = {1'b0, c};
    if (cf.parity != MSO_PAR_NONE)
      f[cf.seven_bits ? 8 : 9] = (cf.parity == MSO_PAR_ODD) ? ~p : p;
    return f;
  endfunction : build_frame

  // ****************************************
  // Analog source and scaling
  // ****************************************
  // Source selection feeds the scaler; relative adds the display offset.
  always_comb
  begin
    unique case (cfg.src)
      MSO_SRC_REL: src_val = 32'(meter.abs_val + meter.offset);
      MSO_SRC_ABS: src_val = meter.abs_val;
      MSO_SRC_TOTAL: src_val = meter.total;
      MSO_SRC_MAX: src_val = meter.max_val;
      MSO_SRC_MIN: src_val = meter.min_val;
      MSO_SRC_SETPOINT_ONE: src_val = signed'(meter.sp_val[0]);
      MSO_SRC_SETPOINT_TWO: src_val = signed'(meter.sp_val[1]);
      MSO_SRC_SETPOINT_THREE: src_val = signed'(meter.sp_val[2]);
      MSO_SRC_SETPOINT_FOUR: src_val = signed'(meter.sp_val[3]);
      default: src_val = '0;
    endcase
  end

  mso_scaler u_scaler (
    .clk(clk),
    .resetn(resetn),
    .value(src_val),
    .low(cfg.low_scale),
    .high(cfg.high_scale),
    .level(scaled)
  );

  // ****************************************
  // Receiver, parser, timing and transmitter
  // ****************************************
  // The receiver only runs while no reply is pending, which keeps the link half duplex.
  always_comb
  begin
    n = q;
    got = 1'b0;
    fr = '0;
    ch = q.rx_sh[6:0];
    db = cfg.seven_bits ? 4'h7 : 4'h8;
    last = db + ((cfg.parity != MSO_PAR_NONE) ? 4'h2 : 4'h1);
    flen = (cfg.seven_bits || cfg.parity == MSO_PAR_NONE) ? FRAME_LEN : FRAME_LEN_PAR;
    rpl = q.cmd == CH_T && (q.rid == CH_W || q.rid == CH_X);
    n.sync = {q.sync[0], rx_pin};
    if (q.st != MSO_ST_RECV)
      n.rx_busy = 1'b0;
    else if (!q.rx_busy)
    begin
      if (!q.sync[1])
      begin
        n.rx_busy = 1'b1;
        n.rx_cnt = {1'b0, cfg.baud_div[15:1]};
        n.rx_bit = '0;
      end
    end
    else if (q.rx_cnt != 16'h0)
      n.rx_cnt = q.rx_cnt - 16'h1;
    else
    begin
      n.rx_cnt = cfg.baud_div - 16'h1;
      n.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0 && q.sync[1])
        n.rx_busy = 1'b0;
      else if (q.rx_bit != 4'h0 && q.rx_bit <= db)
        n.rx_sh[3'(q.rx_bit - 4'h1)] = q.sync[1];
      else if (q.rx_bit == last)
      begin
        n.rx_busy = 1'b0;
        got = 1'b1;
      end
    end
    unique case (q.st)
      MSO_ST_RECV:
      begin
        if (got)
        begin
          if (ch == CH_STAR || ch == CH_DOLLAR)
          begin
            if (q.cmd != 7'h00 && q.rid != 7'h00)
            begin
              n.st = MSO_ST_WAIT;
              n.wcnt = '0;
              n.star = ch == CH_STAR;
            end
            else
              n.cmd = '0;
          end
          else if (q.cmd == 7'h00)
          begin
            if (ch == CH_T || ch == CH_V)
            begin
              n.cmd = ch;
              n.rid = '0;
              n.num = '0;
              n.neg = 1'b0;
              n.fld = '0;
              n.nfld = '0;
            end
          end
          else if (q.rid == 7'h00)
            n.rid = ch;
          else
          begin
            if (ch >= CH_0 && ch <= CH_9 && q.num < NUM_CAP)
              n.num = 20'(q.num * 20'h0a) + 20'(ch - CH_0);
            if (ch == CH_MINUS)
              n.neg = 1'b1;
            if (int'(q.nfld) < N_FLD)
            begin
              n.fld[int'(q.nfld) * 2 +: 2] = (ch == CH_0) ? 2'b10 : (ch == CH_1) ? 2'b11 : 2'b00;
              n.nfld = q.nfld + 3'h1;
            end
          end
        end
      end
      MSO_ST_WAIT:
      begin
        n.wcnt = q.wcnt + 32'h1;
        if (q.wcnt == T2_LAST && q.cmd == CH_V)
        begin
          if (q.rid == CH_W)
            n.lvl = q.neg ? 12'h000 : (q.num > 20'(LEVEL_MAX)) ? LEVEL_MAX : q.num[11:0];
          for (int k = 0; k < N_SP; k++)
          begin
            if (q.rid == CH_X && q.fld[2 * k + 1] && q.am[k])
              n.sp[k] = q.fld[2 * k];
            if (q.rid == CH_U && q.fld[2 * k + 1] && q.fld[2 * k] && !q.am[k])
              n.sp[k] = q.spout[k];
          end
          for (int k = 0; k < N_FLD; k++)
            if (q.rid == CH_U && q.fld[2 * k + 1])
              n.am[k] = q.fld[2 * k];
        end
        if (q.wcnt >= T2_LAST)
        begin
          if (!rpl)
          begin
            n.st = MSO_ST_RECV;
            n.cmd = '0;
          end
          else if (!q.star || q.wcnt >= cfg.tx_delay)
          begin
            n.st = MSO_ST_SEND;
            n.cmd = '0;
            n.oe = 1'b1;
            n.ridx = '0;
            n.tx_left = '0;
            n.tx_cnt = '0;
          end
        end
      end
      MSO_ST_SEND:
      begin
        if (q.tx_cnt != 16'h0)
          n.tx_cnt = q.tx_cnt - 16'h1;
        else if (q.tx_left > 4'h1)
        begin
          n.tx_left = q.tx_left - 4'h1;
          n.tx_sh = {1'b1, q.tx_sh[11:1]};
          n.tx = q.tx_sh[1];
          n.tx_cnt = cfg.baud_div - 16'h1;
        end
        else if (q.ridx < REPLY_LEN)
        begin
          fr = build_frame(reply_char(q.ridx, q.rid == CH_X, q.aout, q.spout), cfg);
          n.tx_sh = fr;
          n.tx = fr[0];
          n.tx_left = flen;
          n.tx_cnt = cfg.baud_div - 16'h1;
          n.ridx = q.ridx + 4'h1;
        end
        else
        begin
          n.st = MSO_ST_RECV;
          n.oe = 1'b0;
          n.tx = 1'b1;
        end
      end
      default: n.st = MSO_ST_RECV;
    endcase
    // Outputs follow the freshly written registers so a manual write lands on the same edge.
    an_man = n.am[AM_ANALOG] || cfg.src == MSO_SRC_MANUAL;
    n.aout = an_man ? n.lvl : scaled;
    for (int k = 0; k < N_SP; k++)
      n.spout[k] = n.am[k] ? n.sp[k] : meter.sp_auto[k];
    unique case (cfg.out_type)
      MSO_OUT_4_20MA: n.rsel = 3'b010;
      MSO_OUT_0_10V: n.rsel = 3'b100;
      default: n.rsel = 3'b001;
    endcase
  end

  // State register; the line idles at mark from reset on.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.sync <= 2'b11;
      q.st <= MSO_ST_RECV;
      q.tx <= 1'b1;
      q.lvl <= LVL_RESET;
      q.sp <= SP_RESET;
      q.am <= AM_RESET;
      q.rsel <= RSEL_RESET;
    end
    else
      q <= n;
  end

  assign tx_pin = q.tx;
  assign tx_oe = q.oe;
  assign analog_level = q.aout;
  assign setpoint_out = q.spout;
  assign range_sel = q.rsel;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_last_bit;
    q.st == MSO_ST_SEND && q.tx_cnt == 16'h0 && q.tx_left <= 4'h1 && q.ridx == REPLY_LEN;
  endsequence
  sequence s_load;
    q.st == MSO_ST_SEND && q.tx_cnt == 16'h0 && q.tx_left <= 4'h1 && q.ridx < REPLY_LEN;
  endsequence
  sequence s_level_write;
    q.st == MSO_ST_WAIT && q.wcnt == T2_LAST && q.cmd == CH_V && q.rid == CH_W &&
      !q.neg && q.num <= 20'h00fff;
  endsequence

  AST_READY_AFTER_REPLY: assert property (s_last_bit |=> q.st == MSO_ST_RECV && !tx_oe)
    else $error("not ready after last reply character");
  AST_HALF_DUPLEX: assert property (q.st != MSO_ST_RECV |-> !q.rx_busy)
    else $error("receiving while a reply is pending");
  AST_IDLE_MARK: assert property (!tx_oe |-> tx_pin)
    else $error("line not at mark while idle");
  AST_REPLY_NOT_EARLY: assert property ($rose(q.st == MSO_ST_SEND) |-> q.wcnt >= T2_LAST)
    else $error("reply started too early");
  AST_STAR_DELAY: assert property ($rose(q.st == MSO_ST_SEND) && q.star |-> q.wcnt >= cfg.tx_delay)
    else $error("reply started before transmit delay");
  AST_EXEC_BOUND: assert property (q.st == MSO_ST_WAIT && q.wcnt >= T2_LAST && !q.star |=>
    q.st != MSO_ST_WAIT)
    else $error("command not finished in time");
  AST_MANUAL_WRITE: assert property (s_level_write ##0 q.am[AM_ANALOG] |=>
    analog_level == 12'($past(q.num)))
    else $error("manual analog write not driven");
  AST_AUTO_WRITE: assert property (s_level_write ##0 !q.am[AM_ANALOG] && cfg.src != MSO_SRC_MANUAL |=>
    analog_level == $past(scaled))
    else $error("automatic analog write reached output");
  AST_START_BIT: assert property (s_load |=> !tx_pin && tx_oe)
    else $error("frame does not open with start bit");
  AST_RANGE_ONEHOT: assert property ($onehot(range_sel))
    else $error("range selection not one-hot");
  AST_SP_AUTO: assert property (q.am[3:0] == 4'h0 && q.st == MSO_ST_RECV |=>
    setpoint_out == $past(meter.sp_auto))
    else $error("automatic setpoints not followed");
endmodule : mso_serial_override

// ---- mso_host.sv ----
// Host computer model on the meter's serial line: sends commands and collects replies.
// Assumes 7 data bits in ten-bit frames and a bit time of BD clock cycles.
// The ninth bit is a second stop bit or a parity bit; the caller judges it from frame.
`timescale 1ns/1ps
module mso_host
  import mso_pkg::*;
#(
  parameter int BD = 8
)(
  input wire logic clk,
  output logic rx_pin,
  input wire logic tx_pin,
  input wire logic tx_oe
);
  int lat;
  logic frame_ok;
  logic [9:0] frame;
  // The line rests at mark, so the receiver never sees a false start.
  initial rx_pin = 1'b1;
  // ****************************************
  // Transmit side
  // ****************************************
  // One frame: start bit, data least significant first, two stop bits, driven at falling edges.
  task automatic send_char(input logic [6:0] c);
    logic [9:0] f;
    f = {2'b11, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_pin = f[i];
      repeat (BD) @(negedge clk);
    end
  endtask : send_char
  // Characters go back to back; a zero idle gap is the awkward case.
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++)
      send_char(7'(s[i]));
  endtask : send_str
  // ****************************************
  // Receive side
  // ****************************************
  // Hunts for a start bit within lim cycles, then samples each bit at its middle.
  task automatic recv_char(input int lim, output logic [6:0] c);
    logic [9:0] b;
    lat = 0;
    while (tx_pin !== 1'b0 && lat < lim)
    begin
      @(negedge clk);
      lat++;
    end
    repeat (BD / 2) @(negedge clk);
    b[0] = tx_pin;
    for (int i = 1; i < 10; i++)
    begin
      repeat (BD) @(negedge clk);
      b[i] = tx_pin;
      frame_ok &= (tx_oe === 1'b1);
    end
    repeat (BD / 2) @(negedge clk);
    c = b[7:1];
    frame_ok &= (b[0] === 1'b0) && (b[9] === 1'b1);
    frame = b;
  endtask : recv_char
endmodule : mso_host

// ---- meter_serial_output_override_bench.sv ----
// Self-checking bench for the serial override block, driven through the host model.
// Assumes a shortened command wait (T2) and an eight-cycle bit time.
`timescale 1ns/1ps
module meter_serial_output_override_bench;
  import mso_pkg::*;
  localparam int T2 = 50;
  localparam int BD = 8;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rx_pin;
  logic tx_pin;
  logic tx_oe;
  mso_cfg_t cfg;
  mso_meter_t meter;
  logic [11:0] analog_level;
  logic [3:0] setpoint_out;
  logic [2:0] range_sel;
  int error_cnt = 0;
  int num_checks = 0;
  // Free-running 250 MHz clock.
  always #2 clk = ~clk;
  mso_serial_override #(.T2_CYC(T2)) dut (
    .clk(clk), .resetn(resetn), .rx_pin(rx_pin), .cfg(cfg), .meter(meter),
    .tx_pin(tx_pin), .tx_oe(tx_oe), .analog_level(analog_level),
    .setpoint_out(setpoint_out), .range_sel(range_sel)
  );
  mso_host #(.BD(BD)) host (.clk(clk), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string msg);
    num_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, want);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // A write gets no reply, so wait out the execution time before the next command.
  task automatic cmd(input string s);
    host.send_str(s);
    repeat (T2 + 3 * BD) @(negedge clk);
  endtask : cmd
  // Reads fourteen reply characters and compares them with the text expected.
  // The ninth frame bit is a second stop without parity, else odd or even parity.
  task automatic reply(input string want, input int dly);
    logic [6:0] c;
    logic par;
    host.frame_ok = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      host.recv_char((i == 0) ? 4 * dly : 2, c);
      if (i == 0)
        chk(host.lat >= dly - 2 * BD && host.lat <= dly + BD, 1, "reply delay");
      chk({25'h0, c}, want[i], "reply char");
      par = (cfg.parity == MSO_PAR_NONE) || ((cfg.parity == MSO_PAR_ODD) ^ (^c));
      chk(host.frame[8], par, "parity bit");
    end
    chk(host.frame_ok, 1, "reply framing");
  endtask : reply
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    repeat (2) @(negedge clk);
    chk(tx_pin, 1, "idle line");
    chk(tx_oe, 0, "driver off");
    chk(range_sel, 3'h1, "range");
    chk(setpoint_out, 4'h5, "auto setpoints");
    repeat (60) @(negedge clk);
    chk(analog_level, 12'h3e8, "auto level");
  endtask : t_reset
  // Auto mode: source, offset, scale ends and range follow the settings; 80 cycles cover two conversions.
  task automatic t_scale();
    cfg.src = MSO_SRC_REL;
    meter.offset = 32'sd500;
    repeat (80) @(negedge clk);
    chk(analog_level, 12'h5dc, "relative source");
    cfg.low_scale = 32'sd1000;
    cfg.high_scale = 32'sd3000;
    cfg.out_type = MSO_OUT_4_20MA;
    repeat (80) @(negedge clk);
    chk(analog_level, 12'h3ff, "scaled ends");
    chk(range_sel, 3'h2, "current range");
    cfg.src = MSO_SRC_MANUAL;
    repeat (80) @(negedge clk);
    chk(analog_level, 12'h000, "manual source");
    cfg.src = MSO_SRC_TOTAL;
    meter.total = 32'sd5000;
    cfg.out_type = MSO_OUT_0_10V;
    repeat (80) @(negedge clk);
    chk(analog_level, 12'hfff, "clamped high");
    chk(range_sel, 3'h4, "voltage range");
    cfg.src = MSO_SRC_MIN;
    meter.min_val = -32'sd5;
    repeat (80) @(negedge clk);
    chk(analog_level, 12'h000, "clamped low");
    cfg.src = MSO_SRC_ABS;
    cfg.low_scale = '0;
    cfg.high_scale = 32'sd4095;
    cfg.out_type = MSO_OUT_0_20MA;
  endtask : t_scale
  task automatic t_auto_write();
    cmd("VW100$");
    chk(analog_level, 12'h3e8, "auto write ignored");
    cmd("VU00011$");
    chk(analog_level, 12'h064, "stored level driven");
    chk(setpoint_out, 4'h5, "held on manual");
  endtask : t_auto_write
  task automatic t_manual_write();
    cmd("VW2047$");
    chk(analog_level, 12'h7ff, "manual write");
    host.send_str("VW5");
    repeat (T2 + 3 * BD) @(negedge clk);
    chk(analog_level, 12'h7ff, "no terminator");
    cmd("0$");
    chk(analog_level, 12'h032, "terminated");
    cmd("VW-5$");
    chk(analog_level, 12'h000, "negative clamped");
    cmd("VW9999$");
    chk(analog_level, 12'hfff, "clamped");
  endtask : t_manual_write
  task automatic t_setpoints();
    cmd("VX1112$");
    chk(setpoint_out, 4'h5, "auto or bad field");
    cmd("VX0001$");
    chk(setpoint_out, 4'hd, "manual field");
    cmd("VX1$");
    chk(setpoint_out, 4'hd, "short write");
  endtask : t_setpoints
  // Reads back to back, each the moment the last reply ends; the dollar reply ignores the delay.
  task automatic t_reads();
    cfg.tx_delay = 32'd100;
    host.send_str("TW*");
    reply("        4095\r\n", 100);
    chk(tx_oe, 0, "driver released");
    cfg.parity = MSO_PAR_ODD;
    host.send_str("TX$");
    reply("        1011\r\n", T2);
    cfg.parity = MSO_PAR_EVEN;
    host.send_str("TW$");
    reply("        4095\r\n", T2);
  endtask : t_reads
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  // Settings start here; t_scale and t_reads change them during the run.
  initial
  begin
    cfg = '0;
    cfg.baud_div = 16'(BD);
    cfg.seven_bits = 1'b1;
    cfg.parity = MSO_PAR_NONE;
    cfg.out_type = MSO_OUT_0_20MA;
    cfg.src = MSO_SRC_ABS;
    cfg.high_scale = 32'sd4095;
    meter = '0;
    meter.abs_val = 32'sd1000;
    meter.sp_auto = 4'h5;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_scale();
    t_auto_write();
    t_manual_write();
    t_setpoints();
    t_reads();
    end_of_test();
  end
  // The run needs about 10000 cycles; this cuts a hang short well after that.
  initial
  begin
    #200000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end
endmodule : meter_serial_output_override_bench
